/* rtl/module_control_regs.svh */
`ifndef MODULE_CONTROL_REGS_SVH
`define MODULE_CONTROL_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define REG_CONTROL 8'h00
`define REG_COMMAND 8'h04
`define REG_STATUS 8'h08

// control register fields
`define CTL_LED_MODE 0
`define CTL_FAST_ARM 1
`define CTL_WAKE_CFG 2
`define CTL_HOST_DOWN 3
`define CTL_GPIO_OUT 4
`define CTL_GPIO_OE 5
`define CTL_FLASH_BUSY 6
`define CTL_WIDTH 7
`define CTL_RESET 7'h00

// command register fields, write-only pulses
`define CMD_SHUTDOWN 0
`define CMD_FAST_OPT 1
`define CMD_EV_CALL 2
`define CMD_EV_DATA 3
`define CMD_EV_NOTIFY 4

// status register fields
`define STS_STATE_LSB 0
`define STS_PIN_LEVEL 8
`define STS_WAKEUP 9
`define STS_RESUME 10
`define STS_SUPPRESS 11
`define STS_GPIO_IN 12
`define STS_FAST_SEEN 13
`define STS_LINE_LOW 14

////////////////////////////////////////////////////////////////////////////
// timing: times in microseconds, clock in MHz
`define CLK_MHZ 20
`define FAST_SHDN_MIN_US 1000
`define FAST_SHDN_CYCLES (`FAST_SHDN_MIN_US * `CLK_MHZ)
`define RESUME_US 10000
`define RESUME_CYCLES (`RESUME_US * `CLK_MHZ)
`define DEREG_US 100
`define DEREG_CYCLES (`DEREG_US * `CLK_MHZ)

`endif

/* rtl/module_control_pkg.sv */
`default_nettype none

package module_control_pkg;

  // power sequencing states, one-hot
  typedef enum logic [4:0] {
    st_off   = 5'b00001,
    st_on    = 5'b00010,
    st_flush = 5'b00100,
    st_dereg = 5'b01000,
    st_final = 5'b10000
  } seq_state_t;

  typedef enum logic [1:0] {
    resp_okay   = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_t;

endpackage

`default_nettype wire

/* rtl/ctrl_link_if.sv */
`timescale 1ns/100ps
`default_nettype none

// carries the fast shutdown line between sequencer and its filter
interface ctrl_link_if;
  logic pin_n;
  logic trigger;
  logic line_low;
  modport filt (input pin_n, output trigger, output line_low);
  modport ctl (output pin_n, input trigger, input line_low);
endinterface

`default_nettype wire

/* rtl/fast_shutdown_filter.sv */
`timescale 1ns/100ps
`default_nettype none

module fast_shutdown_filter #(
  parameter int unsigned MIN_CYCLES = 20000
) (
  input wire logic aclk,
  input wire logic aresetn,
  ctrl_link_if.filt link
);
  localparam int unsigned CW = $clog2(MIN_CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES);

  logic sync1;
  logic sync2;
  logic [CW-1:0] low_cnt;
  logic trig;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser, idles high like the pulled-up pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= link.pin_n;
      sync2 <= sync1;
    end
  end

  // count low cycles; fire once on the cycle past the threshold
  // a release before that just clears the count, so short glitches vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= '0;
      trig <= 1'b0;
    end else if (sync2) begin
      low_cnt <= '0;
      trig <= 1'b0;
    end else begin
      trig <= (low_cnt == LIMIT);
      if (low_cnt <= LIMIT) begin
        low_cnt <= low_cnt + CW'(1);
      end
    end
  end

  assign link.trigger = trig;
  assign link.line_low = ~sync2;
endmodule // fast_shutdown_filter

`default_nettype wire

/* rtl/module_control_signals.sv */
`timescale 1ns/100ps
`default_nettype none
`include "module_control_regs.svh"

module module_control_signals #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned FAST_MIN_CYCLES = `FAST_SHDN_CYCLES,
  parameter int unsigned RESUME_CYCLES = `RESUME_CYCLES,
  parameter int unsigned DEREG_CYCLES = `DEREG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // module pins
  input wire logic ignition_input,
  input wire logic fast_shutdown_n,
  output var logic fast_shutdown_pullup,
  input wire logic power_state_indicator_in,
  output var logic power_state_indicator_out,
  output var logic power_state_indicator_oe,
  input wire logic shared_line_led_in,
  output var logic shared_line_led_out,
  output var logic shared_line_led_oe,
  output var logic wakeup_output,
  output var logic usb_remote_resume,
  output var logic unsolicited_notification
);
  localparam int unsigned RW = $clog2(RESUME_CYCLES + 1);
  localparam int unsigned DW = $clog2(DEREG_CYCLES + 1);

  // merge a written word into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  module_control_pkg::seq_state_t state;
  module_control_pkg::seq_state_t next_state;
  logic [`CTL_WIDTH-1:0] control;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_got;
  logic w_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic fast_mode;
  logic suppress;
  logic fast_seen;
  logic [DW-1:0] dereg_cnt;
  logic [RW-1:0] resume_cnt;

  ctrl_link_if link();

  ////////////////////////////////////////////////////////////////////////////
  // fast shutdown line filter
  assign link.pin_n = fast_shutdown_n;

  fast_shutdown_filter #(
    .MIN_CYCLES(FAST_MIN_CYCLES)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link.filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel decode
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire [ADDR_W-1:0] wr_word = aw_addr & ~ADDR_W'(3);
  wire wr_ctl = do_write & (wr_word == ADDR_W'(`REG_CONTROL));
  wire wr_cmd = do_write & (wr_word == ADDR_W'(`REG_COMMAND));
  wire wr_sts = do_write & (wr_word == ADDR_W'(`REG_STATUS));
  wire wr_ok = wr_ctl | wr_cmd | wr_sts;
  wire [31:0] wmask = merge(32'h0000_0000, w_data, w_strb);
  // a call result cannot be sliced, so the merged word gets a name
  wire [31:0] ctl_merged = merge({25'h0000000, control}, w_data, w_strb);
  wire next_aw_got = (aw_got | aw_hs) & ~do_write;
  wire next_w_got = (w_got | w_hs) & ~do_write;
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  // command pulses only count in their own cycle
  wire cmd_shdn = wr_cmd & wmask[`CMD_SHUTDOWN];
  wire cmd_fast = wr_cmd & wmask[`CMD_FAST_OPT];
  wire ev_notify = wr_cmd & wmask[`CMD_EV_NOTIFY];
  wire ev_any = wr_cmd & (wmask[`CMD_EV_CALL] | wmask[`CMD_EV_DATA] |
                wmask[`CMD_EV_NOTIFY]);

  // axi read channel decode
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire [ADDR_W-1:0] rd_word = s_axi_araddr & ~ADDR_W'(3);
  wire rd_ctl = rd_word == ADDR_W'(`REG_CONTROL);
  wire rd_cmd = rd_word == ADDR_W'(`REG_COMMAND);
  wire rd_sts = rd_word == ADDR_W'(`REG_STATUS);
  wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  ////////////////////////////////////////////////////////////////////////////
  // shared line: led use locks out the general-purpose function
  wire led_mode = control[`CTL_LED_MODE];
  wire led_on = (state == module_control_pkg::st_on);
  wire next_line_out = led_mode ? led_on : control[`CTL_GPIO_OUT];
  wire next_line_oe = led_mode | control[`CTL_GPIO_OE];
  wire gpio_in_seen = ~led_mode & shared_line_led_in;

  // status word assembled for reads
  wire [31:0] status_word = {17'h00000, link.line_low, fast_seen,
                gpio_in_seen, suppress, usb_remote_resume, wakeup_output,
                power_state_indicator_in, 3'h0, state};
  wire [31:0] rd_data = rd_ctl ? {25'h0000000, control} :
                rd_sts ? status_word : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // fast shutdown start: armed feature and a long enough low pulse
  wire fast_go = link.trigger & control[`CTL_FAST_ARM];
  wire in_on = (state == module_control_pkg::st_on);
  wire start_shdn = in_on & (cmd_shdn | fast_go);
  wire flash_idle = ~control[`CTL_FLASH_BUSY];

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      module_control_pkg::st_off: begin
        if (!ignition_input) begin
          next_state = module_control_pkg::st_on;
        end
      end
      module_control_pkg::st_on: begin
        if (start_shdn) begin
          next_state = module_control_pkg::st_flush;
        end
      end
      module_control_pkg::st_flush: begin
        // pending flash writes always finish, fast or not
        if (flash_idle) begin
          next_state = fast_mode ? module_control_pkg::st_final
                                 : module_control_pkg::st_dereg;
        end
      end
      module_control_pkg::st_dereg: begin
        if (dereg_cnt == '0) begin
          next_state = module_control_pkg::st_final;
        end
      end
      module_control_pkg::st_final: begin
        next_state = module_control_pkg::st_off;
      end
      default: begin
        next_state = module_control_pkg::st_off;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
    end
  end

  // captured write payloads and response code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bresp <= module_control_pkg::resp_okay;
    end else begin
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_ok ? module_control_pkg::resp_okay
                             : module_control_pkg::resp_slverr;
      end
    end
  end

  // read channel: data is taken at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= module_control_pkg::resp_okay;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= (rd_ctl | rd_cmd | rd_sts)
                       ? module_control_pkg::resp_okay
                       : module_control_pkg::resp_slverr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, byte-strobed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= `CTL_RESET;
    end else if (wr_ctl) begin
      control <= ctl_merged[`CTL_WIDTH-1:0];
    end
  end

  // sticky fast-shutdown flag, write one to clear; a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_seen <= 1'b0;
    end else if (start_shdn & ~cmd_shdn) begin
      fast_seen <= 1'b1;
    end else if (wr_sts & wmask[`STS_FAST_SEEN]) begin
      fast_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state, shutdown flavour and deregistration timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= module_control_pkg::st_off;
      fast_mode <= 1'b0;
      suppress <= 1'b0;
      dereg_cnt <= '0;
    end else begin
      state <= next_state;
      if (start_shdn) begin
        fast_mode <= fast_go | cmd_fast;
        suppress <= ~fast_go & cmd_fast;
      end else if (state == module_control_pkg::st_final) begin
        suppress <= 1'b0;
      end
      if (next_state == module_control_pkg::st_dereg &&
          state != module_control_pkg::st_dereg) begin
        dereg_cnt <= DW'(DEREG_CYCLES);
      end else if (dereg_cnt != '0) begin
        dereg_cnt <= dereg_cnt - DW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain power indicator: pull low only while the module is up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_state_indicator_out <= 1'b0;
      power_state_indicator_oe <= 1'b0;
      fast_shutdown_pullup <= 1'b0;
    end else begin
      power_state_indicator_out <= 1'b0;
      fast_shutdown_pullup <= 1'b1;
      if (state == module_control_pkg::st_off && !ignition_input) begin
        power_state_indicator_oe <= 1'b1;
      end else if (state == module_control_pkg::st_final) begin
        power_state_indicator_oe <= 1'b0;
      end
    end
  end

  // shared line drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_line_led_out <= 1'b0;
      shared_line_led_oe <= 1'b0;
    end else begin
      shared_line_led_out <= next_line_out;
      shared_line_led_oe <= next_line_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // notifications: none at all once a fast-option command is under way, unless the fast shutdown pin fires in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unsolicited_notification <= 1'b0;
    end else begin
      unsolicited_notification <= ~suppress &
        ((ev_notify & in_on) | (state == module_control_pkg::st_final));
    end
  end

  // wake the sleeping host: dedicated line, else usb remote resume
  // the line stays high until software marks the host awake again or clears the wake config bit
  wire host_down = control[`CTL_HOST_DOWN];
  wire wake_ev = ev_any & in_on & host_down;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_output <= 1'b0;
      usb_remote_resume <= 1'b0;
      resume_cnt <= '0;
    end else begin
      if (!host_down || !control[`CTL_WAKE_CFG]) begin
        wakeup_output <= 1'b0;
      end else if (wake_ev) begin
        wakeup_output <= 1'b1;
      end
      if (wake_ev && !control[`CTL_WAKE_CFG] && resume_cnt == '0) begin
        resume_cnt <= RW'(RESUME_CYCLES);
        usb_remote_resume <= 1'b1;
      end else if (resume_cnt != '0) begin
        resume_cnt <= resume_cnt - RW'(1);
        usb_remote_resume <= (resume_cnt != RW'(1));
      end
    end
  end
endmodule // module_control_signals

`default_nettype wire

/* verif/module_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

module module_control_monitor #(
  parameter int unsigned RESUME_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ignition_input,
  input wire logic fast_shutdown_pullup,
  input wire logic power_state_indicator_out,
  input wire logic power_state_indicator_oe,
  input wire logic usb_remote_resume,
  input wire logic unsolicited_notification
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] resume_len;

  ////////////////////////////////////////
  // length of a resume pulse, read at its end, too long for a repetition
  always_ff @(posedge aclk) begin
    if (!aresetn || !usb_remote_resume) resume_len <= 32'h0;
    else resume_len <= resume_len + 32'h1;
  end

  ////////////////////////////////////////
  a_drain_only: assert property (power_state_indicator_out == 1'b0)
    else $error("indicator driven high");
  a_off_hold: assert property (
    !power_state_indicator_oe && ignition_input
    |=> !power_state_indicator_oe) else $error("left off state");
  a_ignite_now: assert property (
    !power_state_indicator_oe && !ignition_input
    |=> power_state_indicator_oe) else $error("indicator late");
  a_pullup_on: assert property ($past(aresetn) |-> fast_shutdown_pullup)
    else $error("pull-up not enabled");
  a_notify_pulse: assert property (unsolicited_notification
    |=> !unsolicited_notification) else $error("notification too long");
  a_resume_len: assert property ($fell(usb_remote_resume)
    |-> resume_len == RESUME_CYCLES) else $error("resume length wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_write_turn: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready
    |=> (!s_axi_awready && !s_axi_bvalid) ##1 (s_axi_bvalid && !s_axi_awready))
    else $error("write answer timing");
endmodule // module_control_monitor

`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic aclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic led_oe,
  input wire logic led_out,
  output var logic ignition_input,
  output var logic fast_shutdown_n,
  output wire logic pin_level,
  output wire logic led_level
);
  // board pull-ups: a released line reads high
  assign pin_level = pin_oe ? pin_out : 1'b1;
  assign led_level = led_oe ? led_out : 1'b1;

  initial begin
    ignition_input = 1'b1;
    fast_shutdown_n = 1'b1;
  end

  // ignition low for exactly one sampling edge
  task automatic power_on();
    @(posedge aclk);
    ignition_input <= 1'b0;
    @(posedge aclk);
    ignition_input <= 1'b1;
  endtask

  // ignition driven high on the same edge as the shutdown line falls
  task automatic shutdown_pulse(input int len);
    @(posedge aclk);
    ignition_input <= 1'b1;
    fast_shutdown_n <= 1'b0;
    repeat (len) @(posedge aclk);
    fast_shutdown_n <= 1'b1;
  endtask
endmodule // host_model

`default_nettype wire

/* verif/module_control_signals_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "module_control_regs.svh"

module module_control_signals_test;
  localparam int FAST = 8;
  typedef struct packed {
    logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] b;
    logic [31:0] q;
  } row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, seen;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fast_shutdown_pullup, power_state_indicator_out;
  logic power_state_indicator_oe, shared_line_led_out, shared_line_led_oe;
  logic wakeup_output, usb_remote_resume, unsolicited_notification;
  logic ignition_input, fast_shutdown_n, pin_level, led_level;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, n, p;
  row_t rows [5] = '{
    '{`REG_CONTROL, 32'h7f, 4'h1, module_control_pkg::resp_okay, 32'h7f},
    '{`REG_CONTROL, 32'h00, 4'h0, module_control_pkg::resp_okay, 32'h7f},
    '{`REG_CONTROL, 32'h00, 4'hf, module_control_pkg::resp_okay, 32'h00},
    '{8'h0c, 32'hff, 4'hf, module_control_pkg::resp_slverr, 32'h00},
    '{`REG_COMMAND, 32'h00, 4'hf, module_control_pkg::resp_okay, 32'h00}};

  ////////////////////////////////////////
  module_control_signals #(.FAST_MIN_CYCLES(FAST), .RESUME_CYCLES(4),
    .DEREG_CYCLES(3)) u_module_control_signals (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ignition_input, .fast_shutdown_n, .fast_shutdown_pullup,
    .power_state_indicator_in(pin_level), .power_state_indicator_out,
    .power_state_indicator_oe, .shared_line_led_in(led_level),
    .shared_line_led_out, .shared_line_led_oe, .wakeup_output,
    .usb_remote_resume, .unsolicited_notification);
  host_model u_host_model (.aclk, .pin_oe(power_state_indicator_oe),
    .pin_out(power_state_indicator_out), .led_oe(shared_line_led_oe),
    .led_out(shared_line_led_out), .ignition_input, .fast_shutdown_n,
    .pin_level, .led_level);

  ////////////////////////////////////////
  // clock and a hang guard sized well above the whole run
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // bready raised only once bvalid is seen, so the hold is exercised
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // cycles until the indicator is released, counting notifications
  task automatic wait_off();
    n = 0;
    p = 0;
    while (power_state_indicator_oe !== 1'b0 && n < 200) begin
      @(posedge aclk);
      n++;
      if (unsolicited_notification === 1'b1) p++;
    end
    repeat (3) begin
      @(posedge aclk);
      if (unsolicited_notification === 1'b1) p++;
    end
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`REG_STATUS);
    chk("status", 32'h1101, d);
    chk("pullup", 32'h1, {31'h0, fast_shutdown_pullup});
    $display("test reset done");
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s);
      chk("bresp", {30'h0, rows[i].b}, {30'h0, r});
      axi_rd(rows[i].a);
      chk("rdata", rows[i].q, d);
      chk("rresp", {30'h0, rows[i].b}, {30'h0, r});
    end
    $display("test registers done");
    u_host_model.power_on();
    #1;
    chk("oe on", 32'h1, {31'h0, power_state_indicator_oe});
    axi_wr(`REG_CONTROL, 32'h01, 4'hf);
    axi_rd(`REG_STATUS);
    chk("led status", 32'h0002, d);
    chk("led out", 32'h3, {30'h0, shared_line_led_oe, shared_line_led_out});
    axi_wr(`REG_CONTROL, 32'h20, 4'hf);
    chk("gpio out", 32'h2, {30'h0, shared_line_led_oe, shared_line_led_out});
    $display("test led done");
    axi_wr(`REG_CONTROL, 32'h00, 4'hf);
    u_host_model.shutdown_pulse(FAST + 8);
    axi_wr(`REG_CONTROL, 32'h02, 4'hf);
    u_host_model.shutdown_pulse(FAST);
    repeat (6) @(posedge aclk);
    chk("no start", 32'h1, {31'h0, power_state_indicator_oe});
    axi_wr(`REG_CONTROL, 32'h42, 4'hf);
    u_host_model.shutdown_pulse(FAST + 4);
    repeat (20) @(posedge aclk);
    chk("flush wait", 32'h1, {31'h0, power_state_indicator_oe});
    axi_wr(`REG_CONTROL, 32'h02, 4'hf);
    wait_off();
    chk("flush exit", 32'h1, {31'h0, n <= 10});
    axi_rd(`REG_STATUS);
    chk("fast seen", 32'h3101, d);
    axi_wr(`REG_STATUS, 32'h2000, 4'hf);
    axi_rd(`REG_STATUS);
    chk("seen clear", 32'h1101, d);
    u_host_model.power_on();
    #1;
    fork
      u_host_model.shutdown_pulse(FAST + 12);
      wait_off();
    join
    chk("no dereg", 32'h1, {31'h0, n > FAST && n <= FAST + 10});
    chk("pin notify", 32'h1, p);
    $display("test fast shutdown done");
    u_host_model.power_on();
    axi_wr(`REG_CONTROL, 32'h42, 4'hf);
    axi_wr(`REG_COMMAND, 32'h03, 4'hf);
    // busy flash parks the sequence in flush so the flag can be read
    axi_rd(`REG_STATUS);
    chk("suppress", 32'h1, {31'h0, d[11]});
    axi_wr(`REG_CONTROL, 32'h02, 4'hf);
    wait_off();
    chk("fast notify", 32'h0, p);
    u_host_model.power_on();
    axi_wr(`REG_COMMAND, 32'h01, 4'hf);
    wait_off();
    chk("normal notify", 32'h1, p);
    chk("dereg wait", 32'h1, {31'h0, n > 3});
    $display("test command shutdown done");
    u_host_model.power_on();
    for (int ev = 2; ev <= 4; ev++) begin
      axi_wr(`REG_CONTROL, 32'h0c, 4'hf);
      axi_wr(`REG_COMMAND, 32'h1 << ev, 4'hf);
      repeat (2) @(posedge aclk);
      chk("wake", 32'h1, {31'h0, wakeup_output});
      axi_wr(`REG_CONTROL, 32'h04, 4'hf);
      repeat (2) @(posedge aclk);
      chk("wake clear", 32'h0, {31'h0, wakeup_output});
    end
    axi_wr(`REG_COMMAND, 32'h04, 4'hf);
    repeat (2) @(posedge aclk);
    chk("host up", 32'h0, {31'h0, wakeup_output});
    axi_wr(`REG_CONTROL, 32'h08, 4'hf);
    seen = 1'b0;
    fork
      axi_wr(`REG_COMMAND, 32'h08, 4'hf);
      repeat (12) @(posedge aclk) if (usb_remote_resume === 1'b1) seen = 1'b1;
    join
    chk("resume", 32'h1, {31'h0, seen});
    chk("no line", 32'h0, {31'h0, wakeup_output});
    $display("test wakeup done");
    // reset in mid-run while the module is on
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`REG_STATUS);
    chk("reset again", 32'h1101, d);
    chk("oe reset", 32'h0, {31'h0, power_state_indicator_oe});
    $display("test reset again done");
    stop_test();
  end
endmodule // module_control_signals_test

bind module_control_signals module_control_monitor #(
  .RESUME_CYCLES(RESUME_CYCLES)) u_module_control_monitor (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ignition_input, .fast_shutdown_pullup,
  .power_state_indicator_out, .power_state_indicator_oe,
  .usb_remote_resume, .unsolicited_notification);

`default_nettype wire
